//--- hdl/sld_pkg.sv
// Constants shared by the serial line command decoder.
// Assumes one 25 MHz clock domain and byte-wide streams on both sides.
package sld_pkg;
  // Reserved codes
  localparam logic [7:0] CODE_DATA_MODE = 8'hE1;
  localparam logic [7:0] CODE_CMD_MODE = 8'hE3;
  localparam logic [7:0] CODE_PULSE_STOP = 8'hF1;
  // Fixed answer bytes
  localparam logic [7:0] RESP_SPU_ONE = 8'hEF;
  localparam logic [7:0] RESP_SPU_ZERO = 8'hEC;
  localparam logic [7:0] RESP_ARM_ONE = 8'hF6;
  localparam logic [7:0] RESP_ARM_ZERO = 8'h76;
  // Command field positions
  localparam int BIT_KIND = 7;
  localparam int FN_HI = 7;
  localparam int FN_LO = 5;
  localparam int BIT_OPT = 4;
  localparam int SPD_HI = 3;
  localparam int SPD_LO = 2;
  localparam int BIT_PUP = 1;
  localparam int BIT_ONE = 0;
  // Function codes in bits 7..5 and the speed field a pulse needs
  localparam logic [2:0] FN_SINGLE = 3'h4;
  localparam logic [2:0] FN_ACCEL = 3'h5;
  localparam logic [2:0] FN_RESET = 3'h6;
  localparam logic [2:0] FN_PULSE = 3'h7;
  localparam logic [1:0] SPD_FIELD_PULSE = 2'h3;
  // Speed field codes and their decoded values
  localparam logic [1:0] SPD_FIELD_FLEX = 2'h1;
  localparam logic [1:0] SPD_FIELD_OD = 2'h2;
  localparam logic [1:0] SPEED_REG = 2'h0;
  localparam logic [1:0] SPEED_FLEX = 2'h1;
  localparam logic [1:0] SPEED_OD = 2'h2;
  // Reset answer layout
  localparam logic [1:0] RST_RESP_TOP = 2'h3;
  localparam logic RST_RESP_RSVD = 1'b0;
  // Bus engine operations
  localparam logic [1:0] OP_RESET = 2'h0;
  localparam logic [1:0] OP_SLOT = 2'h1;
  localparam logic [1:0] OP_BYTE = 2'h2;
  // Answer buffer
  localparam int RESP_DEPTH = 2;
  localparam int RESP_WIDTH = 8;
endpackage

//--- hdl/sld_command_decoder.sv
// Command decoder: host bytes in, bus requests and answer bytes out.
// Assumes a UART receiver and transmitter and a bus timing engine on ref_clk.
`timescale 1ns/1ps

// Functional notes
// [RULE_01] Commands are bytes; MSB splits communication/configuration
// [RULE_02] E1 data mode, E3 command mode, F1 stop
// [RULE_03] One answer per legal command, listed exceptions
// [RULE_04] Illegal command bytes get no answer
// [RULE_05] F1 yields the terminated pulse's answer
// [RULE_06] Speed bits latched, effective at once
// [RULE_07] Speed 00/11 regular, 01 flexible, 10 overdrive
// [RULE_08] Bits 7..5 pick function; bit0 one
// [RULE_09] Reset answer bits 1..0 report bus reaction
// [RULE_10] Reset answer: revision in 4..2, 7..6 ones
// [RULE_11] Reset answer bit 5 reserved
// [RULE_12] Single bit: one slot, bit4 sets value
// [RULE_13] Slot answer echoes command, bits 1..0 sampled
// [RULE_14] Slot pullup then EF or EC
// [RULE_15] Accelerator flag from bit 4, no bus
// [RULE_16] Host disarms per-byte pullup before accelerator
// [RULE_17] Pulse: bit4 type, bit1 arms per-byte pullup
// [RULE_18] Host avoids risky pulse and arm combinations
// [RULE_19] F1 in command mode ends pulse early
// [RULE_20] Pulse answer at pulse end, low bits undefined
// [RULE_21] Armed data byte pullup ends with F6/76
// [RULE_22] E3 in data mode checks next byte
// [RULE_23] Link is 8N1, one stop bit returned
// [RULE_24] First byte after reset only calibrates
// [RULE_25] MSB-clear commands go to configuration unit
module sld_command_decoder
  import sld_pkg::*;
#(
  parameter logic [2:0] CHIP_REV = 3'h5, // Arbitrary revision value
  parameter int DEPTH = RESP_DEPTH,
  parameter int WIDTH = RESP_WIDTH
)
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic breakDet,
  input wire logic [7:0] rxByte,
  input wire logic rxValid,
  output logic rxReady,
  output logic [WIDTH-1:0] txByte,
  output logic txValid,
  input wire logic txReady,
  output logic [7:0] cfgByte,
  output logic cfgValid,
  input wire logic cfgReady,
  output logic calibrate,
  output logic busStart,
  output logic [1:0] busOp,
  output logic [7:0] busArg,
  output logic [1:0] busSpeed,
  output logic accelOn,
  input wire logic busDone,
  input wire logic [7:0] busResult,
  output logic pulseOn,
  output logic pulseProg,
  output logic pulseStop,
  input wire logic pulseEnd,
  output logic dataMode
);

  typedef enum logic [1:0] {MODE_CMD, MODE_DATA, MODE_CHECK} sld_mode_e;
  typedef enum logic [2:0] {S_CAL, S_IDLE, S_CFG, S_BUS, S_RESP, S_PULSE} sld_state_e;

  ////////////////////////////////////////////////////////////////////////////
  // Decoder state

  sld_state_e state, next_state;
  sld_mode_e mode, next_mode;
  logic [1:0] speed, next_speed;
  logic accel, next_accel;
  logic armed, next_armed;
  logic [1:0] curOp, next_curOp;
  logic [7:0] cmd, next_cmd;
  logic [7:0] respByte, next_respByte;
  logic [7:0] pulseResp, next_pulseResp;
  logic pulseAfter, next_pulseAfter;
  logic lastMsb, next_lastMsb;
  logic next_busStart, next_pulseOn, next_pulseProg, next_pulseStop, next_calibrate;
  logic [7:0] next_busArg, next_cfgByte;
  logic [1:0] next_busOp;
  logic accept, execCmd, illegal, push, full;
  logic [7:0] cmdIn;
  logic [2:0] fn;
  logic [1:0] spdField;

  always_comb
  begin
    next_state = state;
    next_mode = mode;
    next_speed = speed;
    next_accel = accel;
    next_armed = armed;
    next_curOp = curOp;
    next_cmd = cmd;
    next_respByte = respByte;
    next_pulseResp = pulseResp;
    next_pulseAfter = pulseAfter;
    next_lastMsb = lastMsb;
    next_busStart = 1'b0;
    next_busOp = busOp;
    next_busArg = busArg;
    next_pulseOn = pulseOn;
    next_pulseProg = pulseProg;
    next_pulseStop = 1'b0;
    next_calibrate = 1'b0;
    next_cfgByte = cfgByte;
    execCmd = 1'b0;
    illegal = 1'b0;
    push = 1'b0;
    cmdIn = rxByte;
    fn = rxByte[FN_HI:FN_LO];
    spdField = rxByte[SPD_HI:SPD_LO];
    // Data-mode pulses stall input so no data byte is lost behind them
    rxReady = (state == S_CAL) || (state == S_IDLE) || (state == S_PULSE && mode == MODE_CMD);
    accept = rxValid && rxReady;
    unique case (state)
      S_CAL:
        if (accept)
        begin
          next_calibrate = 1'b1; // see [RULE_24]
          next_state = S_IDLE;
        end
      S_IDLE:
        if (accept)
        begin
          unique case (mode)
            MODE_DATA:
              if (rxByte == CODE_CMD_MODE)
                next_mode = MODE_CHECK; // see [RULE_22]
              else
              begin
                next_busStart = 1'b1;
                next_busOp = OP_BYTE;
                next_busArg = rxByte;
                next_curOp = OP_BYTE;
                next_lastMsb = rxByte[BIT_KIND];
                next_state = S_BUS;
              end
            MODE_CHECK:
              if (rxByte == CODE_CMD_MODE)
              begin
                next_mode = MODE_DATA; // see [RULE_22]
                next_busStart = 1'b1;
                next_busOp = OP_BYTE;
                next_busArg = rxByte;
                next_curOp = OP_BYTE;
                next_lastMsb = rxByte[BIT_KIND];
                next_state = S_BUS;
              end
              else
              begin
                next_mode = MODE_CMD; // see [RULE_22]
                execCmd = 1'b1;
              end
            default:
              execCmd = 1'b1;
          endcase
        end
      S_CFG:
        if (cfgReady)
          next_state = S_IDLE;
      S_BUS:
        if (busDone)
        begin
          next_state = S_RESP;
          next_pulseAfter = 1'b0;
          unique case (curOp)
            OP_RESET:
              // see [RULE_09] [RULE_10] [RULE_11]
              next_respByte = {RST_RESP_TOP, RST_RESP_RSVD, CHIP_REV, busResult[1:0]};
            OP_SLOT:
            begin
              // see [RULE_13]
              next_respByte = {cmd[7:2], busResult[0], busResult[0]};
              next_pulseAfter = cmd[BIT_PUP]; // see [RULE_14]
              next_pulseResp = busResult[0] ? RESP_SPU_ONE : RESP_SPU_ZERO;
            end
            default:
            begin
              next_respByte = busResult;
              // Per-byte pullup relies on the host disarming it for accelerator use
              next_pulseAfter = armed; // see [RULE_21] [RULE_16]
              next_pulseResp = lastMsb ? RESP_ARM_ONE : RESP_ARM_ZERO;
            end
          endcase
        end
      S_RESP:
        if (!full)
        begin
          push = 1'b1; // see [RULE_03]
          if (pulseAfter)
          begin
            next_pulseOn = 1'b1; // see [RULE_14] [RULE_21]
            next_pulseProg = 1'b0;
            next_pulseAfter = 1'b0;
            next_state = S_PULSE;
          end
          else
            next_state = S_IDLE;
        end
      S_PULSE:
        // Other command bytes during a pulse are dropped
        if ((accept && rxByte == CODE_PULSE_STOP) || pulseEnd)
        begin
          next_pulseOn = 1'b0; // see [RULE_19] [RULE_20]
          next_pulseStop = accept && rxByte == CODE_PULSE_STOP;
          next_respByte = pulseResp; // see [RULE_05]
          next_state = S_RESP;
        end
    endcase
    if (execCmd)
    begin
      // see [RULE_01] [RULE_02] [RULE_08]
      if (cmdIn == CODE_DATA_MODE)
        next_mode = MODE_DATA;
      else if (cmdIn == CODE_CMD_MODE || cmdIn == CODE_PULSE_STOP)
        next_mode = MODE_CMD;
      else if (!cmdIn[BIT_KIND])
      begin
        next_cfgByte = cmdIn; // see [RULE_25]
        next_state = S_CFG;
      end
      else if (!cmdIn[BIT_ONE])
        illegal = 1'b1; // see [RULE_04]
      else
      begin
        if (fn != FN_PULSE)
          // see [RULE_06] [RULE_07]
          next_speed = (spdField == SPD_FIELD_FLEX) ? SPEED_FLEX :
                       (spdField == SPD_FIELD_OD) ? SPEED_OD : SPEED_REG;
        unique case (fn)
          FN_SINGLE:
          begin
            next_busStart = 1'b1; // see [RULE_12]
            next_busOp = OP_SLOT;
            next_busArg = cmdIn;
            next_curOp = OP_SLOT;
            next_cmd = cmdIn;
            next_state = S_BUS;
          end
          FN_ACCEL:
            if (cmdIn[BIT_PUP])
            begin
              illegal = 1'b1;
              next_speed = speed;
            end
            else
              next_accel = cmdIn[BIT_OPT]; // see [RULE_15]
          FN_RESET:
            if (cmdIn[BIT_PUP])
            begin
              illegal = 1'b1;
              next_speed = speed;
            end
            else
            begin
              next_busStart = 1'b1;
              next_busOp = OP_RESET;
              next_busArg = cmdIn;
              next_curOp = OP_RESET;
              next_state = S_BUS;
            end
          FN_PULSE:
            if (spdField != SPD_FIELD_PULSE)
              illegal = 1'b1; // see [RULE_08]
            else
            begin
              // see [RULE_17] [RULE_18]
              next_armed = cmdIn[BIT_PUP];
              next_pulseOn = 1'b1;
              next_pulseProg = cmdIn[BIT_OPT];
              next_pulseResp = {cmdIn[7:2], 2'h0}; // see [RULE_20]
              next_state = S_PULSE;
            end
          default:
            illegal = 1'b1;
        endcase
      end
    end
  end

  // Break detection acts as a master reset back to calibration
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n || breakDet)
    begin
      state <= S_CAL;
      mode <= MODE_CMD;
      speed <= SPEED_REG;
      accel <= 1'b0;
      armed <= 1'b0;
      curOp <= OP_RESET;
      cmd <= 8'h00;
      respByte <= 8'h00;
      pulseResp <= 8'h00;
      pulseAfter <= 1'b0;
      lastMsb <= 1'b0;
      busStart <= 1'b0;
      busOp <= OP_RESET;
      busArg <= 8'h00;
      pulseOn <= 1'b0;
      pulseProg <= 1'b0;
      pulseStop <= 1'b0;
      calibrate <= 1'b0;
      cfgByte <= 8'h00;
    end
    else
    begin
      state <= next_state;
      mode <= next_mode;
      speed <= next_speed;
      accel <= next_accel;
      armed <= next_armed;
      curOp <= next_curOp;
      cmd <= next_cmd;
      respByte <= next_respByte;
      pulseResp <= next_pulseResp;
      pulseAfter <= next_pulseAfter;
      lastMsb <= next_lastMsb;
      busStart <= next_busStart;
      busOp <= next_busOp;
      busArg <= next_busArg;
      pulseOn <= next_pulseOn;
      pulseProg <= next_pulseProg;
      pulseStop <= next_pulseStop;
      calibrate <= next_calibrate;
      cfgByte <= next_cfgByte;
    end
  end

  assign busSpeed = speed;
  assign accelOn = accel;
  assign dataMode = (mode != MODE_CMD);
  assign cfgValid = (state == S_CFG);

  ////////////////////////////////////////////////////////////////////////////
  // Answer buffer, feeds the 8N1 transmitter (one stop bit, see [RULE_23])

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  logic [WIDTH-1:0] mem [DEPTH];
  logic [WIDTH-1:0] next_mem [DEPTH];
  logic [PW-1:0] wrPtr, rdPtr, next_wrPtr, next_rdPtr;
  logic [PW:0] count, next_count;
  logic pop;

  always_comb
  begin
    pop = txValid && txReady;
    next_mem = mem;
    next_wrPtr = wrPtr;
    next_rdPtr = rdPtr;
    if (push)
    begin
      next_mem[wrPtr] = respByte;
      next_wrPtr = (wrPtr == PW'(DEPTH - 1)) ? '0 : wrPtr + 1'b1;
    end
    if (pop)
      next_rdPtr = (rdPtr == PW'(DEPTH - 1)) ? '0 : rdPtr + 1'b1;
    next_count = count + (PW + 1)'(push) - (PW + 1)'(pop);
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n || breakDet)
    begin
      wrPtr <= '0;
      rdPtr <= '0;
      count <= '0;
    end
    else
    begin
      wrPtr <= next_wrPtr;
      rdPtr <= next_rdPtr;
      count <= next_count;
    end
    mem <= next_mem;
  end

  assign full = (count == (PW + 1)'(DEPTH));
  assign txValid = (count != '0);
  assign txByte = mem[rdPtr];

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n || breakDet);

  a_calib_silent: assert property (state == S_CAL && rxValid |=> calibrate && !busStart && state == S_IDLE) else $error("first byte not calibration only"); // see [RULE_24]
  a_mode_switch: assert property (execCmd && rxByte == CODE_DATA_MODE |=> dataMode ##0 count == $past(count) - $past(pop)) else $error("data mode switch wrong"); // see [RULE_02]
  a_illegal_quiet: assert property (execCmd && illegal |=> state == S_IDLE && !busStart && !pulseOn) else $error("illegal byte acted on"); // see [RULE_04]
  a_speed_od: assert property (execCmd && !illegal && fn != FN_PULSE && rxByte[BIT_KIND] && spdField == SPD_FIELD_OD |=> busSpeed == SPEED_OD) else $error("speed decode wrong"); // see [RULE_07]
  a_accel_flag: assert property (execCmd && !illegal && fn == FN_ACCEL && rxByte[BIT_KIND] |=> accelOn == $past(rxByte[BIT_OPT]) && !busStart && state == S_IDLE) else $error("accelerator flag wrong"); // see [RULE_15]
  a_reset_resp: assert property (state == S_BUS && busDone && curOp == OP_RESET |=> respByte[7:6] == RST_RESP_TOP && respByte[4:2] == CHIP_REV && respByte[1:0] == $past(busResult[1:0])) else $error("reset answer wrong"); // see [RULE_10]
  a_slot_echo: assert property (state == S_BUS && busDone && curOp == OP_SLOT |=> respByte[7:2] == cmd[7:2] && respByte[1] == respByte[0]) else $error("slot answer wrong"); // see [RULE_13]
  a_pulse_abort: assert property (state == S_PULSE && mode == MODE_CMD && rxValid && rxByte == CODE_PULSE_STOP |=> !pulseOn && pulseStop && respByte == $past(pulseResp) ##1 !pulseStop) else $error("pulse not stopped"); // see [RULE_19] [RULE_05]
  a_no_overflow: assert property (full |-> !push ##1 count <= (PW + 1)'(DEPTH)) else $error("answer buffer overrun"); // see [RULE_03]

  c_reset_op: cover property (state == S_BUS && busDone && curOp == OP_RESET);
  c_pulse_abort: cover property (pulseStop);
  c_check_dup: cover property (mode == MODE_CHECK && accept && rxByte == CODE_CMD_MODE);
  c_buffer_full: cover property (full && state == S_RESP);

endmodule

//--- sim/sld_bus_model.sv
// Far-side bus timing engine model for the serial line command decoder.
// Assumes busStart and pulseOn are registered outputs on ref_clk.
`timescale 1ns/1ps
module sld_bus_model
  import sld_pkg::*;
#(
  parameter int PULSE_CYC = 20
)
(
  input wire logic ref_clk,
  input wire logic busStart,
  input wire logic [1:0] busOp,
  input wire logic [7:0] busArg,
  input wire logic pulseOn,
  input wire logic [1:0] react,
  input wire logic [2:0] lag,
  input wire logic holdPulse,
  output logic busDone,
  output logic [7:0] busResult,
  output logic pulseEnd
);
  int busCnt = 0;
  int pulseCnt = 0;
  ////////////////////////////////////////////////////////////////////////////////
  always @(posedge ref_clk)
  begin
    if (busStart)
      busCnt <= int'(lag) + 1;
    else if (busCnt > 0)
      busCnt <= busCnt - 1;
    // Result only valid with busDone; toggled otherwise so stale data never passes
    if (busCnt == 1 && !busStart)
    begin
      busDone <= 1'b1;
      if (busOp == OP_RESET)
        busResult <= {6'h00, react};
      else if (busOp == OP_SLOT)
        busResult <= {7'h00, busArg[BIT_OPT]};
      else
        busResult <= busArg;
    end
    else
    begin
      busDone <= 1'b0;
      busResult <= ~busResult;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  // Held pulses last until the host stops them
  always @(posedge ref_clk)
  begin
    if (pulseOn && !holdPulse && pulseCnt == PULSE_CYC - 1)
    begin
      pulseEnd <= 1'b1;
      pulseCnt <= 0;
    end
    else
    begin
      pulseEnd <= 1'b0;
      pulseCnt <= pulseOn ? pulseCnt + 1 : 0;
    end
  end
endmodule

//--- sim/serial_line_command_decoder_bench.sv
// Self-checking bench for the serial line command decoder.
// Assumes the bus engine model on the far side; host and transmitter are driven here.
`timescale 1ns/1ps
module serial_line_command_decoder_bench
  import sld_pkg::*;
;
  localparam logic [2:0] REV = 3'h2; // Arbitrary revision value
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic breakDet = 1'b0;
  logic [7:0] rxByte = 8'h00;
  logic rxValid = 1'b0;
  logic txReady = 1'b0;
  logic cfgReady = 1'b0;
  logic holdPulse = 1'b0;
  logic stall = 1'b0;
  logic [1:0] react = 2'h1;
  logic [2:0] lag = 3'h1;
  logic rxReady, txValid, cfgValid, calibrate, busStart, accelOn, busDone, pulseOn;
  logic pulseProg, pulseStop, pulseEnd, dataMode;
  logic [7:0] txByte, cfgByte, busArg, busResult;
  logic [1:0] busOp, busSpeed;
  logic [15:0] expq[$];
  logic [7:0] cfgq[$];
  logic [15:0] e;
  int err_total = 0;
  int n_checks = 0;
  int nCal = 0;
  int nBus = 0;
  int nStop = 0;
  always #20 ref_clk = ~ref_clk;
  sld_command_decoder #(.CHIP_REV(REV)) i_dut (.ref_clk(ref_clk), .rst_n(rst_n),
    .breakDet(breakDet), .rxByte(rxByte), .rxValid(rxValid), .rxReady(rxReady),
    .txByte(txByte), .txValid(txValid), .txReady(txReady), .cfgByte(cfgByte),
    .cfgValid(cfgValid), .cfgReady(cfgReady), .calibrate(calibrate), .busStart(busStart),
    .busOp(busOp), .busArg(busArg), .busSpeed(busSpeed), .accelOn(accelOn),
    .busDone(busDone), .busResult(busResult), .pulseOn(pulseOn), .pulseProg(pulseProg),
    .pulseStop(pulseStop), .pulseEnd(pulseEnd), .dataMode(dataMode));
  sld_bus_model i_bus (.ref_clk(ref_clk), .busStart(busStart), .busOp(busOp),
    .busArg(busArg), .pulseOn(pulseOn), .react(react), .lag(lag), .holdPulse(holdPulse),
    .busDone(busDone), .busResult(busResult), .pulseEnd(pulseEnd));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic fail(input string m);
    err_total++;
    $display("mismatch at %0t: %s", $time, m);
  endtask
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input logic [7:0] m);
    n_checks++;
    if ((got & m) !== (exp & m))
      fail($sformatf("answer %h expected %h", got, exp));
  endtask
  task automatic chkv(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp)
      fail($sformatf("level %h expected %h", got, exp));
  endtask
  task automatic want(input logic [7:0] v, input logic [7:0] m);
    expq.push_back({m, v});
  endtask
  function automatic logic [1:0] spd(input logic [1:0] f);
    return (f == SPD_FIELD_FLEX) ? SPEED_FLEX : (f == SPD_FIELD_OD) ? SPEED_OD : SPEED_REG;
  endfunction
  // Holds the byte until taken, then leaves one idle edge
  task automatic send(input logic [7:0] b);
    int n;
    n = 0;
    rxByte = b;
    rxValid = 1'b1;
    while (rxReady !== 1'b1 && n < 3000)
    begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    if (n == 3000)
      fail("host byte refused");
    @(posedge ref_clk);
    #1;
    rxValid = 1'b0;
    @(posedge ref_clk);
    #1;
  endtask
  // Other bytes offered during a command-mode pulse are dropped
  task automatic pulse_over();
    int n;
    n = 0;
    while (pulseOn !== 1'b1 && n < 3000)
    begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    while (pulseOn === 1'b1 && n < 3000)
    begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    if (n == 3000)
      fail("pulse never ended");
  endtask
  // Quiet tail catches answers that should never come
  task automatic test_end(input string t);
    int n;
    n = 0;
    while (expq.size() != 0 && n < 3000)
    begin
      @(posedge ref_clk);
      n++;
    end
    if (expq.size() != 0)
      fail("answer missing");
    repeat (40) @(posedge ref_clk);
    #1;
    $display("test %s done at %0t", t, $time);
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  always @(posedge ref_clk)
  begin
    if (txValid === 1'b1 && txReady === 1'b1)
    begin
      if (expq.size() == 0)
        fail("unexpected answer byte");
      else
      begin
        e = expq.pop_front();
        chk8(txByte, e[7:0], e[15:8]);
      end
    end
    if (cfgValid === 1'b1 && cfgReady === 1'b1)
    begin
      if (cfgq.size() == 0)
        fail("unexpected config byte");
      else
        chk8(cfgByte, cfgq.pop_front(), 8'hFF);
    end
    if (calibrate === 1'b1)
      nCal++;
    if (busStart === 1'b1)
      nBus++;
    if (pulseStop === 1'b1)
      nStop++;
    #1;
    txReady = !stall && ($urandom_range(0, 1) == 1);
    cfgReady = ($urandom_range(0, 1) == 1);
  end
  initial
  begin
    #2000000;
    fail("watchdog expired");
    report_and_stop();
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    logic [7:0] c;
    logic [7:0] d;
    logic [7:0] slots[4];
    logic [7:0] bad[6];
    int nb;
    slots = '{8'h93, 8'h8B, 8'h85, 8'h9D};
    bad = '{8'h80, 8'hC3, 8'hF5, 8'hB3, 8'hE3, 8'hF1};
    d = 8'($urandom(32'h19054C31));
    repeat (20) @(posedge ref_clk);
    #1;
    rst_n = 1'b1;
    send(8'hC1);
    test_end("calibration");
    chkv(8'(nBus), 8'h00);
    for (int i = 0; i < 4; i++)
    begin
      c = 8'hC1 | 8'(i << 2);
      react = 2'(i);
      lag = 3'($urandom_range(0, 7));
      want({2'h3, 1'b0, REV, react}, 8'hDF);
      send(c);
      chkv(8'(busOp), 8'(OP_RESET));
      chkv(busArg, c);
      chkv(8'(busSpeed), 8'(spd(c[3:2])));
      test_end("bus reset");
    end
    stall = 1'b1;
    fork
      begin
        repeat (300) @(posedge ref_clk);
        #1;
        stall = 1'b0;
      end
    join_none
    foreach (slots[k])
    begin
      c = slots[k];
      want({c[7:2], {2{c[4]}}}, 8'hFF);
      if (c[1])
        want(c[4] ? RESP_SPU_ONE : RESP_SPU_ZERO, 8'hFF);
      send(c);
      chkv(busArg, c);
      chkv(8'(busSpeed), 8'(spd(c[3:2])));
      if (c[1])
        pulse_over();
    end
    test_end("single slots");
    nb = nBus;
    send(8'hB5);
    chkv(8'(accelOn), 8'h01);
    chkv(8'(busSpeed), 8'(SPEED_FLEX));
    send(8'hA9);
    chkv(8'(accelOn), 8'h00);
    chkv(8'(busSpeed), 8'(SPEED_OD));
    foreach (bad[k])
      send(bad[k]);
    chkv(8'(busSpeed), 8'(SPEED_OD));
    test_end("silent commands");
    chkv(8'(nBus - nb), 8'h00);
    holdPulse = 1'b1;
    want(8'hEC, 8'hFC);
    send(8'hED);
    chkv(8'(pulseOn), 8'h01);
    chkv(8'(pulseProg), 8'h00);
    repeat (30) @(posedge ref_clk);
    #1;
    chkv(8'(expq.size()), 8'h01);
    send(CODE_PULSE_STOP);
    chkv(8'(nStop), 8'h01);
    chkv(8'(pulseOn), 8'h00);
    holdPulse = 1'b0;
    want(8'hFC, 8'hFC);
    send(8'hFD);
    chkv(8'(pulseProg), 8'h01);
    pulse_over();
    want(8'hEC, 8'hFC);
    send(8'hEF);
    test_end("pulses");
    send(CODE_DATA_MODE);
    chkv(8'(dataMode), 8'h01);
    for (int k = 0; k < 3; k++)
    begin
      d = 8'($urandom_range(0, 8'hE2));
      want(d, 8'hFF);
      want(d[7] ? RESP_ARM_ONE : RESP_ARM_ZERO, 8'hFF);
      send(d);
    end
    want(CODE_CMD_MODE, 8'hFF);
    want(RESP_ARM_ONE, 8'hFF);
    send(CODE_CMD_MODE);
    send(CODE_CMD_MODE);
    chkv(8'(dataMode), 8'h01);
    want(8'hEC, 8'hFC);
    send(CODE_CMD_MODE);
    send(8'hED);
    chkv(8'(dataMode), 8'h00);
    test_end("data mode");
    cfgq.push_back(8'h17);
    send(8'h17);
    test_end("configuration");
    chkv(8'(cfgq.size()), 8'h00);
    breakDet = 1'b1;
    @(posedge ref_clk);
    #1;
    breakDet = 1'b0;
    nb = nBus;
    send(8'hC5);
    test_end("master reset");
    chkv(8'(nCal), 8'h02);
    chkv(8'(nBus - nb), 8'h00);
    report_and_stop();
  end
endmodule
